// [sfr_core.sv]
// Register-command slice of a serial flash: latch control, flag clear,
// boot-read stream, boot configuration and learning-pattern registers.
// Assumes the host clocks data in on rising link-clock edges and samples on
// the next rising edge; the link clock idles whenever chip select is high.
module sfr_core #(
   parameter int NV_PHASE_CYC = sfr_pkg::NV_PHASE_CYC,
   parameter logic [31:0] BOOT_CFG_INIT = sfr_pkg::BOOT_CFG_RST,
   parameter logic [7:0] PAT_INIT = sfr_pkg::PAT_RST
) (
   // System
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Serial link
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic [3:0] I_IO,
   output logic [3:0] O_IO,
   output logic [3:0] O_IO_OE,
   // Array read-back for the boot stream
   output logic [sfr_pkg::ADDR_W-1:0] O_ARRAY_ADDR,
   input wire logic [7:0] I_ARRAY_BYTE,
   // Configuration and fault pins
   input wire logic I_QUAD_MODE,
   input wire logic I_ERASE_FAIL,
   input wire logic I_PROGRAM_FAIL,
   // State visible outside
   output logic [sfr_pkg::SR_W-1:0] O_STATUS_REG_ONE,
   output logic [sfr_pkg::CFG_W-1:0] O_BOOT_READ_CONFIG,
   output logic [sfr_pkg::PAT_W-1:0] O_VOLATILE_PATTERN,
   output logic [sfr_pkg::PAT_W-1:0] O_NONVOLATILE_PATTERN
);
   import sfr_pkg::*;

   // System-domain state; all but the nonvolatile pattern is read by the link while a frame runs
   logic [CFG_W-1:0] boot_cfg_r, boot_cfg_nxt;
   logic [PAT_W-1:0] vpat_r, vpat_nxt;
   logic [PAT_W-1:0] nvpat_r, nvpat_nxt;
   logic boot_arm_r, boot_arm_nxt;
   logic quad_s;

   // Link frame: counters cleared by chip select, records kept across it
   logic frame_rst;
   logic [CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
   logic [4:0] rd_idx_r, rd_idx_nxt;
   logic [7:0] dly_cnt_r, dly_cnt_nxt;
   logic boot_on_r, boot_on_nxt;
   logic [2:0] bib_r, bib_nxt;
   logic [ADDR_W-1:0] byte_cnt_r, byte_cnt_nxt;
   logic frame_tog_r, frame_tog_nxt;
   logic [CNT_W-1:0] rec_cnt_r, rec_cnt_nxt;
   logic [7:0] rec_op_r, rec_op_nxt;
   logic [CFG_W-1:0] rec_sr_r, rec_sr_nxt;
   logic rec_boot_r, rec_boot_nxt;
   logic rec_byte_r, rec_byte_nxt;
   logic [3:0] io_r, io_nxt;
   logic [3:0] oe_r, oe_nxt;
   logic boot_frame;
   logic byte_last;
   logic [7:0] boot_dly;

   // Chip select high clears the frame side at once, so a cut frame leaves
   // no stale bit count or stale output bit behind
   assign frame_rst = I_SYS_RST | I_CS_N;
   assign boot_frame = boot_arm_r;
   assign boot_dly = boot_cfg_r[BC_DLY_LSB +: BC_DLY_W];
   assign byte_last = quad_s ? (bib_r == 3'h1) : (bib_r == 3'h7);

   always_comb begin
      bit_cnt_nxt = (bit_cnt_r == '1) ? bit_cnt_r : bit_cnt_r + 7'h01;
      rd_idx_nxt = rd_idx_r;
      dly_cnt_nxt = dly_cnt_r;
      boot_on_nxt = boot_on_r;
      bib_nxt = bib_r;
      byte_cnt_nxt = byte_cnt_r;
      frame_tog_nxt = frame_tog_r;
      rec_cnt_nxt = (bit_cnt_r == '0) ? 7'h01 : bit_cnt_nxt;
      rec_op_nxt = rec_op_r;
      rec_sr_nxt = rec_sr_r;
      rec_boot_nxt = rec_boot_r;
      rec_byte_nxt = rec_byte_r;
      if (bit_cnt_r == '0) begin
         frame_tog_nxt = ~frame_tog_r;
         rec_boot_nxt = boot_frame;
         rec_byte_nxt = 1'b0;
      end
      if (boot_frame) begin
         // Serial input is not sampled at all in a boot frame
         if (!boot_on_r) begin
            if (dly_cnt_r == boot_dly) begin
               boot_on_nxt = 1'b1;
            end else begin
               dly_cnt_nxt = dly_cnt_r + 8'h01;
            end
         end else if (byte_last) begin
            bib_nxt = '0;
            byte_cnt_nxt = byte_cnt_r + 32'h0000_0001;
            rec_byte_nxt = 1'b1;
         end else begin
            bib_nxt = bib_r + 3'h1;
         end
      end else if (bit_cnt_r < FR_OPC) begin
         rec_op_nxt = {rec_op_r[6:0], I_IO[0]};
      end else begin
         rec_sr_nxt = {rec_sr_r[CFG_W-2:0], I_IO[0]};
         rd_idx_nxt = rd_idx_r + 5'h01;
      end
   end

   always_ff @(posedge I_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= '0;
         rd_idx_r <= '0;
         dly_cnt_r <= '0;
         boot_on_r <= 1'b0;
         bib_r <= '0;
         byte_cnt_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         rd_idx_r <= rd_idx_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         boot_on_r <= boot_on_nxt;
         bib_r <= bib_nxt;
         byte_cnt_r <= byte_cnt_nxt;
      end
   end

   // Records survive chip select so the system side can decode the frame
   always_ff @(posedge I_SCK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         frame_tog_r <= 1'b0;
         rec_cnt_r <= '0;
         rec_op_r <= '0;
         rec_sr_r <= '0;
         rec_boot_r <= 1'b0;
         rec_byte_r <= 1'b0;
      end else begin
         frame_tog_r <= frame_tog_nxt;
         rec_cnt_r <= rec_cnt_nxt;
         rec_op_r <= rec_op_nxt;
         rec_sr_r <= rec_sr_nxt;
         rec_boot_r <= rec_boot_nxt;
         rec_byte_r <= rec_byte_nxt;
      end
   end

   // Boot address is the 512-byte unit plus the bytes already sent
   assign O_ARRAY_ADDR = {boot_cfg_r[BC_ADDR_LSB +: BC_ADDR_W], 9'h000} + byte_cnt_r;

   // Config and pattern are read across domains with no handshake; the pattern changes only
   // between frames, but the config changes when an update ends, which can fall inside a frame
   // Output side, changed on falling edges
   always_comb begin
      io_nxt = '0;
      oe_nxt = '0;
      if (boot_frame) begin
         if (boot_on_r) begin
            if (quad_s) begin
               oe_nxt = 4'hf;
               io_nxt = bib_r[0] ? I_ARRAY_BYTE[3:0] : I_ARRAY_BYTE[7:4];
            end else begin
               oe_nxt = 4'h2;
               io_nxt[1] = I_ARRAY_BYTE[~bib_r];
            end
         end
      end else if (bit_cnt_r >= FR_OPC) begin
         if (rec_op_r == OP_BOOT_RD) begin
            oe_nxt = 4'h2;
            io_nxt[1] = boot_cfg_r[{rd_idx_r[4:3], ~rd_idx_r[2:0]}];
         end else if (rec_op_r == OP_PAT_RD) begin
            oe_nxt = 4'h2;
            io_nxt[1] = vpat_r[~rd_idx_r[2:0]];
         end
      end
   end

   always_ff @(negedge I_SCK or posedge frame_rst) begin
      if (frame_rst) begin
         io_r <= '0;
         oe_r <= '0;
      end else begin
         io_r <= io_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign O_IO = io_r;
   assign O_IO_OE = oe_r;

   // System domain
   sfr_tmr_if tmr();
   logic [4:0] sync_q;
   logic cs_s, tog_s, efail_s, pfail_s;
   logic cs_d_r;
   logic seen_tog_r, seen_tog_nxt;
   logic wel_r, wel_nxt;
   logic wip_r, wip_nxt;
   logic eerr_r, eerr_nxt;
   logic perr_r, perr_nxt;
   logic erase_bad_r, erase_bad_nxt;
   logic pend_boot_r, pend_boot_nxt;
   logic [CFG_W-1:0] pend_r, pend_nxt;
   logic new_frame;
   logic writable;
   logic [CFG_W-1:0] rx_word;

   // The synchroniser resets chip select low; the toggle check hides that false edge
   sfr_sync #(
      .W(5)
   ) u_sync (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .i_d({I_CS_N, frame_tog_r, I_QUAD_MODE, I_ERASE_FAIL, I_PROGRAM_FAIL}),
      .o_q(sync_q)
   );

   sfr_nv_timer #(
      .PHASE_CYC(NV_PHASE_CYC)
   ) u_timer (
      .i_clk(I_CLK),
      .i_rst(I_SYS_RST),
      .tmr(tmr.unit)
   );

   assign cs_s = sync_q[4];
   assign tog_s = sync_q[3];
   assign quad_s = sync_q[2];
   assign efail_s = sync_q[1];
   assign pfail_s = sync_q[0];
   // A frame with no clock edge leaves the toggle alone and is ignored
   assign new_frame = cs_s & ~cs_d_r & (tog_s != seen_tog_r);
   assign writable = wel_r & ~wip_r & ~tmr.busy;
   // First received byte is the low byte of the register
   assign rx_word = {rec_sr_r[7:0], rec_sr_r[15:8], rec_sr_r[23:16], rec_sr_r[31:24]};

   always_comb begin
      boot_cfg_nxt = boot_cfg_r;
      vpat_nxt = vpat_r;
      nvpat_nxt = nvpat_r;
      boot_arm_nxt = boot_arm_r;
      seen_tog_nxt = new_frame ? tog_s : seen_tog_r;
      wel_nxt = wel_r;
      wip_nxt = wip_r;
      eerr_nxt = eerr_r;
      perr_nxt = perr_r;
      erase_bad_nxt = erase_bad_r;
      pend_boot_nxt = pend_boot_r;
      pend_nxt = pend_r;
      tmr.start = 1'b0;
      tmr.with_erase = 1'b0;
      if (new_frame && rec_boot_r) begin
         if (rec_byte_r) begin
            boot_arm_nxt = 1'b0;
         end
      end else if (new_frame) begin
         if (rec_op_r == OP_LATCH_SET && rec_cnt_r == FR_OPC) begin
            wel_nxt = 1'b1;
         end else if (rec_op_r == OP_LATCH_CLR && rec_cnt_r == FR_OPC && !wip_r) begin
            wel_nxt = 1'b0;
         end else if (rec_op_r == OP_FLAG_CLR && rec_cnt_r == FR_OPC) begin
            eerr_nxt = 1'b0;
            perr_nxt = 1'b0;
         end else if (rec_op_r == OP_BOOT_WR && rec_cnt_r == FR_WORD && writable) begin
            tmr.start = 1'b1;
            tmr.with_erase = 1'b1;
            wip_nxt = 1'b1;
            pend_boot_nxt = 1'b1;
            pend_nxt = rx_word;
            erase_bad_nxt = 1'b0;
         end else if (rec_op_r == OP_PAT_NV && rec_cnt_r == FR_BYTE && writable) begin
            tmr.start = 1'b1;
            wip_nxt = 1'b1;
            pend_boot_nxt = 1'b0;
            pend_nxt = {24'h000000, rec_sr_r[7:0]};
            erase_bad_nxt = 1'b0;
         end else if (rec_op_r == OP_PAT_V && rec_cnt_r == FR_BYTE && writable) begin
            vpat_nxt = rec_sr_r[7:0];
         end
      end
      // A failed erase is remembered so the program phase cannot store the word
      if (tmr.erase_end && efail_s) begin
         erase_bad_nxt = 1'b1;
         eerr_nxt = 1'b1;
      end
      if (tmr.done) begin
         // Completion overrides a latch set that lands in the same cycle
         wip_nxt = 1'b0;
         wel_nxt = 1'b0;
         if (pfail_s) begin
            perr_nxt = 1'b1;
         end else if (pend_boot_r && !erase_bad_r) begin
            boot_cfg_nxt = pend_r;
         end else if (!pend_boot_r) begin
            nvpat_nxt = pend_r[PAT_W-1:0];
         end
      end
   end

   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         boot_cfg_r <= BOOT_CFG_INIT;
         vpat_r <= PAT_INIT;
         nvpat_r <= PAT_INIT;
         boot_arm_r <= BOOT_CFG_INIT[BC_ENABLE];
         cs_d_r <= 1'b1;
         seen_tog_r <= 1'b0;
         wel_r <= 1'b0;
         wip_r <= 1'b0;
         eerr_r <= 1'b0;
         perr_r <= 1'b0;
         erase_bad_r <= 1'b0;
         pend_boot_r <= 1'b0;
         pend_r <= '0;
      end else begin
         boot_cfg_r <= boot_cfg_nxt;
         vpat_r <= vpat_nxt;
         nvpat_r <= nvpat_nxt;
         boot_arm_r <= boot_arm_nxt;
         cs_d_r <= cs_s;
         seen_tog_r <= seen_tog_nxt;
         wel_r <= wel_nxt;
         wip_r <= wip_nxt;
         eerr_r <= eerr_nxt;
         perr_r <= perr_nxt;
         erase_bad_r <= erase_bad_nxt;
         pend_boot_r <= pend_boot_nxt;
         pend_r <= pend_nxt;
      end
   end

   // Status bits outside this slice read as zero
   always_comb begin
      O_STATUS_REG_ONE = '0;
      O_STATUS_REG_ONE[ST_WIP] = wip_r;
      O_STATUS_REG_ONE[ST_WEL] = wel_r;
      O_STATUS_REG_ONE[ST_EERR] = eerr_r;
      O_STATUS_REG_ONE[ST_PERR] = perr_r;
   end

   assign O_BOOT_READ_CONFIG = boot_cfg_r;
   assign O_VOLATILE_PATTERN = vpat_r;
   assign O_NONVOLATILE_PATTERN = nvpat_r;
endmodule

// [sfr_core_monitor.sv]
// Concurrent checks on the register-command slice, attached by bind.
// Assumes only the top-level ports of the slice are visible.
module sfr_core_monitor #(
   parameter int NV_PHASE_CYC = sfr_pkg::NV_PHASE_CYC
) (
   // System
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Link and pins
   input wire logic I_CS_N,
   input wire logic I_QUAD_MODE,
   input wire logic [3:0] O_IO_OE,
   // State
   input wire logic [sfr_pkg::SR_W-1:0] O_STATUS_REG_ONE,
   input wire logic [sfr_pkg::CFG_W-1:0] O_BOOT_READ_CONFIG,
   input wire logic [sfr_pkg::PAT_W-1:0] O_NONVOLATILE_PATTERN
);
   timeunit 1ns;
   timeprecision 100ps;
   import sfr_pkg::*;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   logic write_in_progress;
   logic write_enable_latch;
   logic perr;
   logic eerr;
   logic [8:0] busy_r;
   logic [8:0] busy_nxt;
   assign write_in_progress = O_STATUS_REG_ONE[ST_WIP];
   assign write_enable_latch = O_STATUS_REG_ONE[ST_WEL];
   assign perr = O_STATUS_REG_ONE[ST_PERR];
   assign eerr = O_STATUS_REG_ONE[ST_EERR];
   // Counts busy cycles so the self-timed length can be bounded both ways
   always_comb begin
      busy_nxt = write_in_progress ? busy_r + 9'h1 : 9'h0;
   end
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         busy_r <= 9'h0;
      end else begin
         busy_r <= busy_nxt;
      end
   end
   sequence s_done;
      $fell(write_in_progress);
   endsequence
   sequence s_flag_up;
      $rose(perr) || $rose(eerr);
   endsequence
   property p_busy_len;
      s_done |-> busy_r >= NV_PHASE_CYC && busy_r <= 2 * NV_PHASE_CYC + 8;
   endproperty
   property p_cfg_update;
      !$stable(O_BOOT_READ_CONFIG) |-> $past(write_in_progress) || $past(write_in_progress, 2);
   endproperty
   property p_nv_update;
      !$stable(O_NONVOLATILE_PATTERN) |-> $past(write_in_progress) || $past(write_in_progress, 2);
   endproperty
   property p_oe_legal;
      O_IO_OE != 4'h0 |-> O_IO_OE == 4'h2 || (O_IO_OE == 4'hf && I_QUAD_MODE);
   endproperty
   property p_flag_clr;
      $fell(perr) || $fell(eerr) |-> $past(I_CS_N, 2) && $past(I_CS_N, 3);
   endproperty
   wip_rise_a: assert property ($rose(write_in_progress) |-> write_enable_latch)
      else $error("update started without latch");
   busy_len_a: assert property (p_busy_len)
      else $error("self-timed update length off");
   done_latch_a: assert property (s_done |-> ##[0:1] !write_enable_latch)
      else $error("latch left set after update");
   cfg_update_a: assert property (p_cfg_update)
      else $error("boot config changed outside update");
   nv_update_a: assert property (p_nv_update)
      else $error("pattern changed outside update");
   oe_idle_a: assert property (I_CS_N && $past(I_CS_N) |-> O_IO_OE == 4'h0)
      else $error("pins driven while deselected");
   oe_legal_a: assert property (p_oe_legal)
      else $error("illegal output enable pattern");
   flag_clr_a: assert property (p_flag_clr)
      else $error("flag cleared inside a frame");
   flag_set_a: assert property (s_flag_up |-> $past(write_in_progress))
      else $error("fail flag set while idle");
endmodule

// [sfr_host_model.sv]
// Host controller model: chip select, link clock and serial input.
// Assumes the device drives pins on falling link-clock edges.
module sfr_host_model (
   // Pins from the device
   input wire logic [3:0] i_io,
   input wire logic [3:0] i_io_oe,
   // Link
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_io
);
   timeunit 1ns;
   timeprecision 100ps;
   logic si = 1'b0;
   logic junk = 1'b0;
   // One bit per rising edge: was any output enable high when sampled
   logic [79:0] oe_seen = '0;
   // Released lines other than IO0 toggle so a stale value never reads as valid
   always #40 junk = ~junk;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         o_io[i] = i_io_oe[i] ? i_io[i] : ((i == 0) ? si : junk);
      end
   end
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
   end
   // One frame, MSB of tx first; link clock stands low outside frames
   task automatic xfer(input int n, input logic [79:0] tx, input bit quad,
                       output logic [79:0] rx);
      rx = '0;
      oe_seen = '0;
      #13 o_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si = tx[i];
         #40 o_sck = 1'b1;
         rx = quad ? {rx[75:0], o_io} : {rx[78:0], o_io[1]};
         oe_seen = {oe_seen[78:0], |i_io_oe};
         #40 o_sck = 1'b0;
      end
      #40 o_cs_n = 1'b1;
      si = ~si;
      #200;
   endtask
endmodule

// [sfr_nv_timer.sv]
// Self-timed nonvolatile update: optional erase phase, then program phase.
// Assumes a one-cycle start pulse that arrives only while idle.
module sfr_nv_timer #(
   parameter int PHASE_CYC = sfr_pkg::NV_PHASE_CYC
) (
   // System
   input wire logic i_clk,
   input wire logic i_rst,
   // Control
   sfr_tmr_if.unit tmr
);
   import sfr_pkg::*;
   sfr_tmr_state_t st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic last;
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 16'h0001;
      last = (cnt_r == 16'(PHASE_CYC - 1));
      tmr.erase_end = 1'b0;
      tmr.done = 1'b0;
      case (st_r)
         T_IDLE: begin
            cnt_nxt = '0;
            if (tmr.start) begin
               st_nxt = tmr.with_erase ? T_ERASE : T_PROG;
            end
         end
         T_ERASE: begin
            if (last) begin
               tmr.erase_end = 1'b1;
               cnt_nxt = '0;
               st_nxt = T_PROG;
            end
         end
         default: begin
            if (last) begin
               tmr.done = 1'b1;
               st_nxt = T_IDLE;
            end
         end
      endcase
   end
   assign tmr.busy = (st_r != T_IDLE);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= T_IDLE;
         cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [sfr_pkg.sv]
// Constants for the serial flash register-command slice: opcodes, status and
// boot-configuration field layout, frame lengths, reset values and timing.
// Assumes one system clock at 50 MHz and a link clock driven by the host.
package sfr_pkg;
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_CLR = 8'h04;
   localparam logic [7:0] OP_FLAG_CLR = 8'h30;
   localparam logic [7:0] OP_BOOT_RD = 8'h14;
   localparam logic [7:0] OP_BOOT_WR = 8'h15;
   localparam logic [7:0] OP_PAT_NV = 8'h43;
   localparam logic [7:0] OP_PAT_V = 8'h4a;
   localparam logic [7:0] OP_PAT_RD = 8'h41;
   localparam int SR_W = 8;
   localparam int ST_WIP = 0;
   localparam int ST_WEL = 1;
   localparam int ST_EERR = 5;
   localparam int ST_PERR = 6;
   localparam int CFG_W = 32;
   localparam int BC_ENABLE = 0;
   localparam int BC_DLY_LSB = 1;
   localparam int BC_DLY_W = 8;
   localparam int BC_ADDR_LSB = 9;
   localparam int BC_ADDR_W = 23;
   localparam int ADDR_W = 32;
   localparam int PAT_W = 8;
   localparam int CNT_W = 7;
   localparam logic [6:0] FR_OPC = 7'h08;
   localparam logic [6:0] FR_BYTE = 7'h10;
   localparam logic [6:0] FR_WORD = 7'h28;
   localparam logic [31:0] BOOT_CFG_RST = 32'h0000_0000;
   localparam logic [7:0] PAT_RST = 8'h00;
   localparam int CLK_NS = 20;
   localparam int NV_PHASE_NS = 2000;
   localparam int NV_PHASE_CYC = (NV_PHASE_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {T_IDLE, T_ERASE, T_PROG} sfr_tmr_state_t;
endpackage

// [sfr_sync.sv]
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that may change at any time.
module sfr_sync #(
   parameter int W = 1
) (
   // System
   input wire logic i_clk,
   input wire logic i_rst,
   // Levels
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= i_d;
         q_r <= meta_r;
      end
   end
   assign o_q = q_r;
endmodule

// [sfr_tmr_if.sv]
// Handshake between the command core and the self-timed update unit.
// Assumes both ends run on the system clock.
interface sfr_tmr_if;
   logic start;
   logic with_erase;
   logic erase_end;
   logic done;
   logic busy;
   modport ctrl(output start, output with_erase, input erase_end, input done, input busy);
   modport unit(input start, input with_erase, output erase_end, output done, output busy);
endinterface

// [spi_flash_register_commands_tb_top.sv]
// Top bench: resets the slice and runs command frames through the host model.
// Assumes the host model owns the link pins and the bench the rest.
module spi_flash_register_commands_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sfr_pkg::*;
   // Boot enabled, delay 2, start field 1 (byte 200h)
   localparam logic [31:0] INIT = 32'h0000_0205;
   localparam logic [31:0] NEWC = 32'h1234_5600;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic quad = 1'b0;
   logic efail = 1'b0;
   logic pfail = 1'b0;
   logic sck, cs_n;
   logic [3:0] io_in, io_out, io_oe;
   logic [31:0] addr, cfg;
   logic [7:0] arr, st, vpat, nvpat;
   logic [79:0] rx;
   int error_cnt = 0;
   int compares = 0;
   always #10 clk = ~clk;
   assign arr = addr[7:0] ^ 8'h5a;
   sfr_core #(.NV_PHASE_CYC(40), .BOOT_CFG_INIT(INIT)) DUT (
      .I_CLK(clk), .I_SYS_RST(rst), .I_SCK(sck), .I_CS_N(cs_n), .I_IO(io_in),
      .O_IO(io_out), .O_IO_OE(io_oe), .O_ARRAY_ADDR(addr), .I_ARRAY_BYTE(arr),
      .I_QUAD_MODE(quad), .I_ERASE_FAIL(efail), .I_PROGRAM_FAIL(pfail),
      .O_STATUS_REG_ONE(st), .O_BOOT_READ_CONFIG(cfg), .O_VOLATILE_PATTERN(vpat),
      .O_NONVOLATILE_PATTERN(nvpat)
   );
   sfr_host_model host (
      .i_io(io_out), .i_io_oe(io_oe), .o_sck(sck), .o_cs_n(cs_n), .o_io(io_in)
   );
   function automatic logic [31:0] sw(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      #2 rst = 1'b1;
      repeat (10) @(posedge clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic pins(input logic [2:0] v);
      @(posedge clk);
      #2 {quad, efail, pfail} = v;
   endtask
   // Bounded wait for the self-timed update to finish
   task automatic wait_idle();
      int k;
      for (k = 0; k < 400 && st[ST_WIP] !== 1'b0; k++) @(posedge clk);
      if (k == 400) begin
         error_cnt++;
         end_of_test();
      end
      repeat (2) @(posedge clk);
   endtask
   initial begin
      do_reset();
      // Two delay edges and a turnaround carry nothing, then bytes 200h, 201h
      host.xfer(19, 80'h0, 0, rx);
      check(rx[15:0], 16'h5a5b);
      check(host.oe_seen[18:0], 19'h0ffff);
      host.xfer(72, {8'h14, 64'h0}, 0, rx);
      check(rx[63:0], {sw(INIT), sw(INIT)});
      host.xfer(9, 80'h00c, 0, rx);
      check(st[ST_WEL], 1'b0);
      host.xfer(8, 80'h06, 0, rx);
      check(st[ST_WEL], 1'b1);
      host.xfer(8, 80'h04, 0, rx);
      check(st[ST_WEL], 1'b0);
      host.xfer(16, 80'h4a3c, 0, rx);
      check(vpat, PAT_RST);
      host.xfer(8, 80'h06, 0, rx);
      host.xfer(16, 80'h4a3c, 0, rx);
      check({st[ST_WIP], vpat}, 9'h03c);
      host.xfer(24, 80'h41_0000, 0, rx);
      check(rx[15:0], 16'h3c3c);
      // Latch-clear arrives while the boot register update still runs
      host.xfer(40, {8'h15, sw(NEWC)}, 0, rx);
      host.xfer(8, 80'h04, 0, rx);
      check(st[1:0], 2'b11);
      wait_idle();
      check({st[1:0], cfg}, {2'b00, NEWC});
      pins(3'b010);
      host.xfer(8, 80'h06, 0, rx);
      host.xfer(40, {8'h15, 32'h0}, 0, rx);
      wait_idle();
      check({st[6:5], cfg}, {2'b01, NEWC});
      pins(3'b001);
      host.xfer(8, 80'h06, 0, rx);
      host.xfer(16, 80'h43a5, 0, rx);
      wait_idle();
      check({st[6:5], nvpat}, {2'b11, PAT_RST});
      pins(3'b000);
      host.xfer(8, 80'h06, 0, rx);
      host.xfer(8, 80'h30, 0, rx);
      check(st, 8'h02);
      host.xfer(16, 80'h43a5, 0, rx);
      wait_idle();
      check({st, nvpat}, {8'h00, 8'ha5});
      // Reset re-arms boot; quad gives a nibble per edge
      pins(3'b100);
      do_reset();
      check({st, cfg}, {8'h00, INIT});
      host.xfer(7, 80'h0, 1, rx);
      check(rx[15:0], 16'h5a5b);
      check(host.oe_seen[6:0], 7'h0f);
      end_of_test();
   end
endmodule

bind sfr_core sfr_core_monitor #(.NV_PHASE_CYC(NV_PHASE_CYC)) mon (
   .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CS_N(I_CS_N), .I_QUAD_MODE(I_QUAD_MODE),
   .O_IO_OE(O_IO_OE), .O_STATUS_REG_ONE(O_STATUS_REG_ONE),
   .O_BOOT_READ_CONFIG(O_BOOT_READ_CONFIG), .O_NONVOLATILE_PATTERN(O_NONVOLATILE_PATTERN)
);
